//--- inc/sffc_defs.svh
// Constants for the slot enable and FIFO format configuration block.
// Assumes a 32-bit APB register bus with one register per aligned word.
`ifndef SFFC_DEFS_SVH
`define SFFC_DEFS_SVH

// Register indexes; the byte address is four times the index.
`define SFFC_IDX_SLOT_CFG      8'h11
`define SFFC_IDX_AVG_CFG       8'h15
`define SFFC_ADDR_SLOT_CFG     12'h044
`define SFFC_ADDR_AVG_CFG      12'h054

// Slot configuration register fields.
`define SFFC_EN_A_BIT          0
`define SFFC_RSV1_BIT          1
`define SFFC_FMT_A_LSB         2
`define SFFC_FMT_A_MSB         4
`define SFFC_EN_B_BIT          5
`define SFFC_FMT_B_LSB         6
`define SFFC_FMT_B_MSB         8
`define SFFC_RSV_HI_LSB        9
`define SFFC_RSV_HI_MSB        11
`define SFFC_SLOT_CFG_RST      12'h000

// Averaging register fields.
`define SFFC_AVG_A_LSB         4
`define SFFC_AVG_A_MSB         6
`define SFFC_AVG_B_LSB         8
`define SFFC_AVG_B_MSB         10
`define SFFC_AVG_CFG_RST       16'h0000

// Format codes.
`define SFFC_FMT_NONE          3'h0
`define SFFC_FMT_SUM16         3'h1
`define SFFC_FMT_SUM32         3'h2
`define SFFC_FMT_CH16          3'h4
`define SFFC_FMT_CH32          3'h6

// Words of 16 bits emitted per sample for each format.
`define SFFC_WORDS_NONE        4'h0
`define SFFC_WORDS_SUM16       4'h1
`define SFFC_WORDS_SUM32       4'h2
`define SFFC_WORDS_CH16        4'h4
`define SFFC_WORDS_CH32        4'h8

`endif

//--- inc/sffc_pkg.sv
// Types shared by the slot FIFO format configuration block and its bench.
// Assumes the constants of sffc_defs.svh for field layout.
package sffc_pkg;

	// One sample set from the time slot sequencer.
	typedef struct packed {
		logic             slot_b;
		logic [3:0][15:0] ch16;
		logic [3:0][31:0] ch32;
	} sffc_sample_t;

	// One 16-bit word towards the FIFO.
	typedef struct packed {
		logic        slot_b;
		logic        last;
		logic [15:0] data;
	} sffc_word_t;

	typedef enum logic [0:0] {
		SFFC_IDLE = 1'b0,
		SFFC_EMIT = 1'b1
	} sffc_state_t;

endpackage

//--- rtl/sffc_top.sv
// Slot enable and FIFO format configuration with its formatting data path.
// Assumes an APB master on pclk and a sequencer and FIFO that handshake by valid and ready.
`timescale 1ns/1ns
`include "sffc_defs.svh"

// Behaviour
// - Slot B format: none, sum16, sum32
// - Slot B codes 4/6 give per-channel words
// - Slot B stored only if averaging matches or slot A format is none
// - Bit 5 enables slot B, reset zero
// - Slot A format: none, sum16, sum32
// - Slot A codes 4/6 give per-channel words
// - Bit 0 enables slot A, reset zero
module sffc_top #(
	parameter int ADDR_W = 12
) (
	// Clock and reset.
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave.
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_W-1:0]     paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Sample input from the sequencer.
	input  wire logic                  in_valid,
	input  wire sffc_pkg::sffc_sample_t in_sample,
	output logic                       in_ready,
	// Word output towards the FIFO.
	output logic                       out_valid,
	output sffc_pkg::sffc_word_t       out_word,
	input  wire logic                  out_ready,
	// Configuration seen by the rest of the device.
	output logic                       first_slot_enable,
	output logic                       second_slot_enable,
	output logic      [2:0]            first_slot_fifo_format,
	output logic      [2:0]            second_slot_fifo_format
);

	////////////////////////////////////////////////////////////////////////////
	// Register bus.

	logic [11:0] slot_cfg_q;
	logic [15:0] avg_cfg_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;

	wire         hit_slot = (paddr == ADDR_W'(`SFFC_ADDR_SLOT_CFG));
	wire         hit_avg  = (paddr == ADDR_W'(`SFFC_ADDR_AVG_CFG));
	wire         mapped   = hit_slot | hit_avg;
	// The access phase is stretched by one cycle so that pready comes from a flop.
	wire         acc_go   = psel & penable & ~pready_q;
	wire         acc_done = psel & penable & pready_q;
	wire         wr_slot  = acc_done & pwrite & hit_slot;
	wire         wr_avg   = acc_done & pwrite & hit_avg;
	wire [31:0]  rd_mux   = hit_slot ? {20'h0_0000, slot_cfg_q} :
	                        hit_avg  ? {16'h0000, avg_cfg_q} : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= acc_go;
			pslverr_q <= acc_go & ~mapped;
			prdata_q  <= (acc_go & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_cfg_q <= `SFFC_SLOT_CFG_RST;
			avg_cfg_q  <= `SFFC_AVG_CFG_RST;
		end else begin
			if (wr_slot)
				slot_cfg_q <= pwdata[11:0];
			if (wr_avg)
				avg_cfg_q  <= pwdata[15:0];
		end
	end

	wire       en_a  = slot_cfg_q[`SFFC_EN_A_BIT];
	wire       en_b  = slot_cfg_q[`SFFC_EN_B_BIT];
	wire [2:0] fmt_a = slot_cfg_q[`SFFC_FMT_A_MSB:`SFFC_FMT_A_LSB];
	wire [2:0] fmt_b = slot_cfg_q[`SFFC_FMT_B_MSB:`SFFC_FMT_B_LSB];
	wire [2:0] avg_a = avg_cfg_q[`SFFC_AVG_A_MSB:`SFFC_AVG_A_LSB];
	wire [2:0] avg_b = avg_cfg_q[`SFFC_AVG_B_MSB:`SFFC_AVG_B_LSB];

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign first_slot_enable       = slot_cfg_q[`SFFC_EN_A_BIT];
	assign second_slot_enable      = slot_cfg_q[`SFFC_EN_B_BIT];
	assign first_slot_fifo_format  = slot_cfg_q[`SFFC_FMT_A_MSB:`SFFC_FMT_A_LSB];
	assign second_slot_fifo_format = slot_cfg_q[`SFFC_FMT_B_MSB:`SFFC_FMT_B_LSB];

	////////////////////////////////////////////////////////////////////////////
	// Format decode and slot B gating.

	function automatic logic [3:0] words_for(input logic [2:0] fmt);
		case (fmt)
			`SFFC_FMT_SUM16: words_for = `SFFC_WORDS_SUM16;
			`SFFC_FMT_SUM32: words_for = `SFFC_WORDS_SUM32;
			`SFFC_FMT_CH16:  words_for = `SFFC_WORDS_CH16;
			`SFFC_FMT_CH32:  words_for = `SFFC_WORDS_CH32;
			default:         words_for = `SFFC_WORDS_NONE;
		endcase
	endfunction

	// Slot B data shares FIFO frames with slot A, so it is kept only when both average alike or slot A format is none.
	wire       b_allowed = (avg_a == avg_b) | (fmt_a == `SFFC_FMT_NONE);
	wire       is_b      = in_sample.slot_b;
	wire       slot_on   = is_b ? (en_b & b_allowed) : en_a;
	wire [2:0] sel_fmt   = is_b ? fmt_b : fmt_a;
	wire [3:0] sel_words = slot_on ? words_for(sel_fmt) : `SFFC_WORDS_NONE;

	////////////////////////////////////////////////////////////////////////////
	// Word sequencer.

	sffc_pkg::sffc_state_t  state_q;
	sffc_pkg::sffc_sample_t smp_q;
	logic [2:0]             fmt_q;
	logic [3:0]             nwords_q;
	logic [3:0]             idx_q;
	logic                   in_ready_q;
	logic                   buf_ready_q;
	logic [15:0]            sum16;
	logic [31:0]            sum32;
	logic [15:0]            word_data;

	wire take  = in_valid & in_ready_q;
	wire emit  = (state_q == sffc_pkg::SFFC_EMIT);
	wire push  = emit & buf_ready_q;
	wire last  = (idx_q == nwords_q - 4'h1);

	// Sums wrap at their own width; the channels are summed as delivered.
	assign sum16 = smp_q.ch16[0] + smp_q.ch16[1] + smp_q.ch16[2] + smp_q.ch16[3];
	assign sum32 = smp_q.ch32[0] + smp_q.ch32[1] + smp_q.ch32[2] + smp_q.ch32[3];

	// Values of 32 bits go out upper half first.
	always_comb begin
		case (fmt_q)
			`SFFC_FMT_SUM16: word_data = sum16;
			`SFFC_FMT_SUM32: word_data = idx_q[0] ? sum32[15:0] : sum32[31:16];
			`SFFC_FMT_CH16:  word_data = smp_q.ch16[idx_q[1:0]];
			`SFFC_FMT_CH32:  word_data = idx_q[0] ? smp_q.ch32[idx_q[2:1]][15:0] :
			                                        smp_q.ch32[idx_q[2:1]][31:16];
			default:         word_data = 16'h0000;
		endcase
	end

	wire sffc_pkg::sffc_word_t push_word = '{slot_b: smp_q.slot_b, last: last, data: word_data};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= sffc_pkg::SFFC_IDLE;
			in_ready_q <= 1'b0;
			smp_q      <= '0;
			fmt_q      <= `SFFC_FMT_NONE;
			nwords_q   <= `SFFC_WORDS_NONE;
			idx_q      <= 4'h0;
		end else begin
			case (state_q)
				sffc_pkg::SFFC_IDLE: begin
					in_ready_q <= 1'b1;
					if (take) begin
						smp_q    <= in_sample;
						fmt_q    <= sel_fmt;
						nwords_q <= sel_words;
						idx_q    <= 4'h0;
						if (sel_words != `SFFC_WORDS_NONE) begin
							state_q    <= sffc_pkg::SFFC_EMIT;
							in_ready_q <= 1'b0;
						end
					end
				end
				sffc_pkg::SFFC_EMIT: begin
					if (push) begin
						idx_q <= idx_q + 4'h1;
						if (last) begin
							state_q    <= sffc_pkg::SFFC_IDLE;
							in_ready_q <= 1'b1;
						end
					end
				end
				default: begin
					state_q    <= sffc_pkg::SFFC_IDLE;
					in_ready_q <= 1'b0;
				end
			endcase
		end
	end

	assign in_ready = in_ready_q;

	////////////////////////////////////////////////////////////////////////////
	// Two-entry buffer: an output stage and a skid stage, so a stall loses no word.

	logic                 out_v_q;
	logic                 skid_v_q;
	sffc_pkg::sffc_word_t out_q;
	sffc_pkg::sffc_word_t skid_q;

	wire pop      = out_v_q & out_ready;
	wire out_free = ~out_v_q | pop;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_v_q     <= 1'b0;
			skid_v_q    <= 1'b0;
			out_q       <= '0;
			skid_q      <= '0;
			buf_ready_q <= 1'b0;
		end else begin
			if (out_free) begin
				out_v_q  <= skid_v_q | push;
				out_q    <= skid_v_q ? skid_q : push_word;
				skid_v_q <= 1'b0;
			end else if (push) begin
				skid_v_q <= 1'b1;
				skid_q   <= push_word;
			end
			// Ready drops as soon as the skid stage is about to fill.
			buf_ready_q <= ~((skid_v_q & ~out_free) | (~out_free & push));
		end
	end

	assign out_valid = out_v_q;
	assign out_word  = out_q;

endmodule // sffc_top

//--- verif/sffc_top_sva.sv
// Checker for the slot configuration block, seeing only the top ports.
// Assumes the bench binds it to sffc_top on pclk and presetn.
`timescale 1ns/1ns
module sffc_top_sva (
	// Clock and reset.
	input wire logic	pclk,
	input wire logic	presetn,
	// APB.
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic	pready,
	// Streams.
	input wire logic	in_valid,
	input wire sffc_pkg::sffc_sample_t	in_sample,
	input wire logic	in_ready,
	input wire logic	out_valid,
	input wire sffc_pkg::sffc_word_t	out_word,
	input wire logic	out_ready,
	// Configuration.
	input wire logic	first_slot_enable,
	input wire logic	second_slot_enable,
	input wire logic [2:0]	first_slot_fifo_format,
	input wire logic [2:0]	second_slot_fifo_format
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire	wr_done = psel && penable && pwrite && pready;
	wire	take_a = in_valid && in_ready && !in_sample.slot_b && first_slot_enable;
	wire	take_b = in_valid && in_ready && in_sample.slot_b && second_slot_enable;
	////////////////////////////////////////////////////////////////
	en_a_hold_a: assert property (!wr_done |=> $stable(first_slot_enable))
		else $error("first slot enable changed without a write");
	en_b_hold_a: assert property (!wr_done |=> $stable(second_slot_enable))
		else $error("second slot enable changed without a write");
	fmt_a_none_a: assert property (take_a && first_slot_fifo_format == 3'h0 |=> in_ready)
		else $error("slot A sample with no format was not dropped");
	fmt_b_none_a: assert property (take_b && second_slot_fifo_format == 3'h0 |=> in_ready)
		else $error("slot B sample with no format was not dropped");
	ch32_a_a: assert property (take_a && first_slot_fifo_format == 3'h6 |=> ##1 !in_ready [*7])
		else $error("slot A per-channel wide sample ended too soon");
	ch16_b_a: assert property (take_b && second_slot_fifo_format == 3'h4 && first_slot_fifo_format == 3'h0
		|=> ##1 !in_ready [*3])
		else $error("slot B per-channel sample ended too soon");
	apb_answer_a: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered in its second cycle");
	out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
		else $error("stalled output word changed or vanished");
	cover property (take_a && first_slot_fifo_format == 3'h6);
	cover property (take_b && second_slot_fifo_format == 3'h4);
	cover property (out_valid && !out_ready);
endmodule // sffc_top_sva

//--- verif/sffc_sink.sv
// FIFO-side partner: accepts words, fast or slow, and records them.
// Assumes the bench reads and clears the record by hierarchical reference.
`timescale 1ns/1ns
module sffc_sink (
	// Clock and reset.
	input wire logic	pclk,
	input wire logic	presetn,
	// Word stream.
	input wire logic	out_valid,
	input wire sffc_pkg::sffc_word_t	out_word,
	output logic	out_ready,
	// Pace.
	input wire logic	slow
);
	logic [1:0]	gap_q;
	sffc_pkg::sffc_word_t	got[$];
	// A slow sink takes one word in three cycles, so the buffer fills.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q <= 2'h0;
			out_ready <= 1'b0;
		end else begin
			gap_q <= (gap_q == 2'h2) ? 2'h0 : gap_q + 2'h1;
			out_ready <= !slow || gap_q == 2'h2;
			if (out_valid && out_ready)
				got.push_back(out_word);
		end
	end
endmodule // sffc_sink

//--- verif/slot_fifo_format_config_bench.sv
// Bench for the slot configuration block: APB tasks, sample sender, word checks.
// Assumes sffc_top, sffc_sink and the checker are compiled beside it.
`timescale 1ns/1ns
module slot_fifo_format_config_bench;
	logic	pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, in_valid = 0, slow = 0, rerr;
	logic [11:0]	paddr = 12'h000;
	logic [31:0]	pwdata = 32'h0000_0000, rd, cfg;
	sffc_pkg::sffc_sample_t	smp = {1'b0, 64'h4444_3333_2222_1111, 128'hF000_0001_3000_0003_2000_0002_4000_0004};
	wire [31:0]	prdata;
	wire	pready, pslverr, in_ready, out_valid, out_ready, first_en, second_en;
	wire [2:0]	first_fmt, second_fmt;
	wire sffc_pkg::sffc_word_t	out_word;
	int	n_fail = 0, n_checks = 0, cyc = 0;
	sffc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.in_valid, .in_sample(smp), .in_ready, .out_valid, .out_word, .out_ready, .first_slot_enable(first_en),
		.second_slot_enable(second_en), .first_slot_fifo_format(first_fmt), .second_slot_fifo_format(second_fmt));
	sffc_sink sink (.pclk, .presetn, .out_valid, .out_word, .out_ready, .slow);
	always #2 pclk = ~pclk;
	////////////////////////////////////////////////////////////////
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Offers one sample, then waits until it is taken and every word has left.
	// Automatic, so the expected word list starts empty on every call.
	task automatic send_expect(input logic b, input logic [2:0] f);
		logic [15:0]	e[$];
		logic [15:0]	s16;
		logic [31:0]	s32;
		@(posedge pclk);
		smp.slot_b <= b;
		in_valid <= 1'b1;
		@(posedge pclk);
		while (in_ready !== 1'b1) @(posedge pclk);
		in_valid <= 1'b0;
		repeat (2) @(posedge pclk);
		while (!(in_ready === 1'b1 && out_valid === 1'b0)) @(posedge pclk);
		s16 = smp.ch16[0] + smp.ch16[1] + smp.ch16[2] + smp.ch16[3];
		s32 = smp.ch32[0] + smp.ch32[1] + smp.ch32[2] + smp.ch32[3];
		for (int i = 0; i < 4; i++) begin
			if (f == 3'h4)
				e.push_back(smp.ch16[i]);
			if (f == 3'h6)
				e.push_back(smp.ch32[i][31:16]);
			if (f == 3'h6)
				e.push_back(smp.ch32[i][15:0]);
		end
		if (f == 3'h1)
			e.push_back(s16);
		if (f == 3'h2)
			e = {s32[31:16], s32[15:0]};
		chk("word count", e.size(), sink.got.size());
		foreach (e[i]) begin
			chk("word data", {16'h0000, e[i]}, {16'h0000, sink.got[i].data});
			chk("word tags", {30'h0, b, i == e.size() - 1}, {30'h0, sink.got[i].slot_b, sink.got[i].last});
		end
		sink.got = {};
	endtask
	task stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h044, 32'h0000_0000);
		chk("slot cfg reset", 32'h0000_0000, rd);
		apb(1'b1, 12'h044, 32'hFFFF_FFFF);
		apb(1'b0, 12'h044, 32'h0000_0000);
		chk("slot cfg all ones", 32'h0000_0FFF, rd);
		apb(1'b0, 12'h080, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, {31'h0, rerr});
		$display("test registers done");
		for (int b = 0; b < 2; b++) begin
			for (int c = 0; c < 8; c++) begin
				cfg = b ? 32'h0000_0020 | (32'(c) << 6) : 32'h0000_0001 | (32'(c) << 2);
				slow <= c[2];
				apb(1'b1, 12'h044, cfg);
				apb(1'b0, 12'h044, 32'h0000_0000);
				chk("slot cfg", cfg, rd);
				chk("cfg outputs", {24'h00_0000, cfg[8:6], cfg[5], cfg[4:2], cfg[0]},
					{24'h00_0000, second_fmt, second_en, first_fmt, first_en});
				send_expect(b[0], (c == 1 || c == 2 || c == 4 || c == 6) ? 3'(c) : 3'h0);
			end
		end
		apb(1'b1, 12'h044, 32'h0000_0118);
		send_expect(1'b0, 3'h0);
		send_expect(1'b1, 3'h0);
		$display("test formats done");
		apb(1'b1, 12'h044, 32'h0000_0065);
		apb(1'b1, 12'h054, 32'h0000_0210);
		apb(1'b0, 12'h054, 32'h0000_0000);
		chk("avg cfg", 32'h0000_0210, rd);
		send_expect(1'b1, 3'h0);
		apb(1'b1, 12'h044, 32'h0000_0061);
		send_expect(1'b1, 3'h1);
		apb(1'b1, 12'h044, 32'h0000_0065);
		apb(1'b1, 12'h054, 32'h0000_0110);
		send_expect(1'b1, 3'h1);
		send_expect(1'b0, 3'h1);
		$display("test averaging gate done");
		stop_test();
	end
endmodule // slot_fifo_format_config_bench

bind sffc_top sffc_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .in_valid, .in_sample,
	.in_ready, .out_valid, .out_word, .out_ready, .first_slot_enable, .second_slot_enable,
	.first_slot_fifo_format, .second_slot_fifo_format);
